// *** hw/nvc_access_ctrl.v ***
// register front end of the nonvolatile byte access controller
`timescale 1ns/100ps
`include "nvc_consts.vh"
module nvc_access_ctrl #(
  parameter AW = 9,
  parameter TW = 16
) (
  input wire core_clk, // system clock
  input wire rst, // synchronous reset, high
  input wire [5:0] io_addr, // register address
  input wire io_wr, // register write strobe
  input wire io_rd, // register read strobe
  input wire [7:0] io_wdata, // write data
  output reg [7:0] io_rdata, // read data
  input wire global_irq_en, // cpu global interrupt enable
  input wire flash_selfprog_busy, // flash self programming active
  input wire osc_tick, // calibrated oscillator pulse
  output wire ready_irq, // ready interrupt request level
  output reg cpu_stall, // halt the cpu
  output reg [AW-1:0] cell_addr, // array byte address
  output reg [7:0] cell_wdata, // array write byte
  output reg cell_erase, // erase phase active
  output reg cell_program, // write phase active
  output reg cell_rd, // array read pulse
  input wire [7:0] cell_rdata // array read byte
);
  // ************************************************************
  // register state
  // ************************************************************
  reg [AW-1:0] nv_byte_address;
  reg [7:0] nv_data_reg;
  reg [1:0] program_action_select;
  reg ready_irq_enable;
  reg write_unlock;
  reg write_strobe;
  reg [2:0] unlock_count;
  reg [2:0] stall_count;
  wire prog_busy;
  wire prog_done;
  wire wr_ctrl;
  wire wr_lo;
  wire wr_hi;
  wire wr_data;
  wire start;
  wire read_go;
  wire [TW-1:0] prog_len;
  wire [7:0] ctrl_view;
  assign wr_ctrl = io_wr && (io_addr == `NVC_OFS_CTRL);
  assign wr_lo = io_wr && (io_addr == `NVC_OFS_ADDR_LO);
  assign wr_hi = io_wr && (io_addr == `NVC_OFS_ADDR_HI);
  assign wr_data = io_wr && (io_addr == `NVC_OFS_DATA);
  // ************************************************************
  // write unlock and strobe
  // ************************************************************
  // strobe only counts with an open unlock and no flash activity
  assign start = wr_ctrl && io_wdata[`NVC_BIT_STROBE] && write_unlock
    && !write_strobe && !prog_busy && !flash_selfprog_busy
    && (program_action_select != `NVC_MODE_RESV);
  assign read_go = wr_ctrl && io_wdata[`NVC_BIT_READ] && !write_strobe;
  // atomic and split operations take different oscillator counts
  assign prog_len = (program_action_select == `NVC_MODE_ATOMIC) ?
    `NVC_OSC_ATOMIC : `NVC_OSC_SPLIT;
  // the unlock window runs four cycles and then closes itself
  always @(posedge core_clk) begin
    if (rst) begin
      write_unlock <= 1'b0;
      unlock_count <= 3'h0;
    end else if (wr_ctrl && io_wdata[`NVC_BIT_UNLOCK]
                 && !io_wdata[`NVC_BIT_STROBE]) begin
      write_unlock <= 1'b1;
      unlock_count <= `NVC_UNLOCK_CYCLES;
    end else if (start) begin
      write_unlock <= 1'b0; // consumed
      unlock_count <= 3'h0;
    end else if (write_unlock) begin
      unlock_count <= unlock_count - 3'h1;
      if (unlock_count == 3'h1)
        write_unlock <= 1'b0;
    end
  end
  // strobe stays high until the timer reports the end
  always @(posedge core_clk) begin
    if (start)
      write_strobe <= 1'b1;
    else if (prog_done)
      write_strobe <= 1'b0;
    else if (rst && !prog_busy)
      write_strobe <= 1'b0;
  end
  initial write_strobe = 1'b0;
  // ************************************************************
  // control fields
  // ************************************************************
  // a busy array keeps its mode across reset
  always @(posedge core_clk) begin
    if (rst) begin
      ready_irq_enable <= 1'b0;
      if (!write_strobe)
        program_action_select <= `NVC_MODE_RESET;
    end else if (wr_ctrl) begin
      ready_irq_enable <= io_wdata[`NVC_BIT_IRQEN];
      if (!write_strobe)
        program_action_select <= io_wdata[5:4];
    end
  end
  initial program_action_select = `NVC_MODE_RESET;
  // ************************************************************
  // address and data
  // ************************************************************
  // address has no reset value; it is frozen while programming
  always @(posedge core_clk) begin
    if (!write_strobe) begin
      if (wr_lo)
        nv_byte_address[7:0] <= io_wdata;
      if (wr_hi)
        nv_byte_address[AW-1:8] <= io_wdata[AW-9:0];
    end
  end
  // read result wins over a cpu write in the same cycle
  always @(posedge core_clk) begin
    if (read_go)
      nv_data_reg <= cell_rdata;
    else if (wr_data)
      nv_data_reg <= io_wdata;
  end
  // ************************************************************
  // array drive
  // ************************************************************
  // latch data and phase enables at the start of programming
  always @(posedge core_clk) begin
    if (rst && !write_strobe) begin
      cell_erase <= 1'b0;
      cell_program <= 1'b0;
    end else if (start) begin
      cell_wdata <= nv_data_reg;
      cell_erase <= program_action_select != `NVC_MODE_WRITE;
      cell_program <= program_action_select != `NVC_MODE_ERASE;
    end else if (prog_done) begin
      cell_erase <= 1'b0;
      cell_program <= 1'b0;
    end
  end
  initial cell_erase = 1'b0;
  initial cell_program = 1'b0;
  always @* begin
    cell_addr = nv_byte_address;
  end
  always @(posedge core_clk) begin
    if (rst)
      cell_rd <= 1'b0;
    else
      cell_rd <= read_go;
  end
  // ************************************************************
  // cpu stall: four after a read, two after a strobe
  // ************************************************************
  always @(posedge core_clk) begin
    if (rst) begin
      stall_count <= 3'h0;
      cpu_stall <= 1'b0;
    end else if (read_go) begin
      stall_count <= `NVC_READ_STALL;
      cpu_stall <= 1'b1;
    end else if (start) begin
      stall_count <= 3'h2;
      cpu_stall <= 1'b1;
    end else if (stall_count != 3'h0) begin
      stall_count <= stall_count - 3'h1;
      cpu_stall <= stall_count != 3'h1;
    end
  end
  // ************************************************************
  // ready interrupt and read back
  // ************************************************************
  assign ready_irq = ready_irq_enable && global_irq_en && !write_strobe
    && !flash_selfprog_busy;
  // strobes and reserved bits read back as the control word shows
  assign ctrl_view = {2'b00, program_action_select, ready_irq_enable,
    write_unlock, write_strobe, 1'b0};
  always @(posedge core_clk) begin
    if (rst)
      io_rdata <= 8'h00;
    else if (io_rd) begin
      case (io_addr)
        `NVC_OFS_ADDR_LO: io_rdata <= nv_byte_address[7:0];
        `NVC_OFS_ADDR_HI:
          io_rdata <= {{(16-AW){1'b0}}, nv_byte_address[AW-1:8]};
        `NVC_OFS_DATA: io_rdata <= nv_data_reg;
        `NVC_OFS_CTRL: io_rdata <= ctrl_view;
        default: io_rdata <= 8'h00;
      endcase
    end
  end
  // ************************************************************
  // programming timer
  // ************************************************************
  nvc_osc_timer #(
    .W(TW)
  ) nvc_osc_timer_inst (
    .core_clk(core_clk),
    .rst(rst),
    .start(start),
    .length(prog_len),
    .osc_tick(osc_tick),
    .busy(prog_busy),
    .done(prog_done)
  );
endmodule // nvc_access_ctrl

// *** pkg/nvc_consts.vh ***
// constants for the nonvolatile byte access controller
// Notes on behaviour
// - address bits 15..9 always read zero
// - nine bit linear byte address
// - address undefined after reset, software sets
// - data register holds write byte, read result
// - mode field picks erase+write, erase, write
// - mode writes ignored while strobe set
// - mode resets to 00 unless busy
// - ready irq needs enable and global enable
// - ready irq is a steady level
// - no ready irq during programming or flash
// - strobe within four cycles of unlock programs
// - unlock self clears after four cycles
// - strobe without unlock does nothing
// - no programming while flash is written
// - control bits 7..6 read zero
// - single bit ops touch only their bit
// - strobe clears when programming time ends
// - read strobe loads data at once, stalls
// - no reads or address change while busy
// - duration counted on calibrated oscillator
`ifndef NVC_CONSTS_VH
`define NVC_CONSTS_VH
`define NVC_OFS_ADDR_LO 6'h21
`define NVC_OFS_ADDR_HI 6'h22
`define NVC_OFS_DATA 6'h20
`define NVC_OFS_CTRL 6'h1F
`define NVC_BIT_READ 0
`define NVC_BIT_STROBE 1
`define NVC_BIT_UNLOCK 2
`define NVC_BIT_IRQEN 3
`define NVC_BIT_MODE_LO 4
`define NVC_BIT_MODE_HI 5
`define NVC_MODE_ATOMIC 2'h0
`define NVC_MODE_ERASE 2'h1
`define NVC_MODE_WRITE 2'h2
`define NVC_MODE_RESV 2'h3
`define NVC_MODE_RESET 2'h0
`define NVC_UNLOCK_CYCLES 3'h4
`define NVC_READ_STALL 3'h4
`define NVC_OSC_ATOMIC 16'h6700
`define NVC_OSC_SPLIT 16'h377A
`endif

// *** hw/nvc_osc_timer.v ***
// counts calibrated oscillator ticks for one programming operation
`timescale 1ns/100ps
module nvc_osc_timer #(
  parameter W = 16
) (
  input wire core_clk, // system clock
  input wire rst, // synchronous reset, high
  input wire start, // one-cycle start pulse
  input wire [W-1:0] length, // oscillator ticks to run
  input wire osc_tick, // one pulse per oscillator cycle
  output reg busy, // operation in progress
  output wire done // one-cycle end pulse
);
  reg [W-1:0] count;
  // counts survive reset so an active operation completes
  always @(posedge core_clk) begin
    if (start) begin
      busy <= 1'b1;
      count <= length;
    end else if (busy && osc_tick) begin
      count <= count - {{(W-1){1'b0}}, 1'b1};
      if (count == {{(W-1){1'b0}}, 1'b1})
        busy <= 1'b0;
    end else if (rst && !busy) begin
      count <= {W{1'b0}};
    end
  end
  // first-time start-up: reset never clears busy, so it starts cleared here
  initial busy = 1'b0;
  assign done = busy && osc_tick && (count == {{(W-1){1'b0}}, 1'b1});
endmodule // nvc_osc_timer

// *** testbench/nvc_access_ctrl_assertions.sv ***
// port assertions for the nonvolatile access controller
`timescale 1ns/100ps
module nvc_checker #(parameter AW = 9) (
  input wire core_clk, // clock
  input wire rst, // reset
  input wire [5:0] io_addr, // reg address
  input wire io_wr, // reg write
  input wire [7:0] io_wdata, // write data
  input wire global_irq_en, // cpu irq enable
  input wire flash_selfprog_busy, // flash busy
  input wire ready_irq, // ready level
  input wire cpu_stall, // stall
  input wire [AW-1:0] cell_addr, // array address
  input wire [7:0] cell_wdata, // array data
  input wire cell_erase, // erase phase
  input wire cell_program, // write phase
  input wire cell_rd // read pulse
);
  // busy is seen only through the cell phases
  wire busy = cell_erase | cell_program;
  wire ctl_wr = io_wr & (io_addr == 6'h1F);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_start; $rose(busy); endsequence
  sequence s_read; ctl_wr && io_wdata[0] && !busy; endsequence
  property p_irq_gate;
    ready_irq |-> global_irq_en && !flash_selfprog_busy;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("irq without enables");
  property p_irq_busy;
    busy |-> !ready_irq;
  endproperty
  a_irq_busy: assert property (p_irq_busy)
    else $error("irq while busy");
  property p_cause;
    s_start |-> $past(ctl_wr && io_wdata[1]);
  endproperty
  a_cause: assert property (p_cause)
    else $error("start without strobe");
  property p_flash;
    s_start |-> !$past(flash_selfprog_busy);
  endproperty
  a_flash: assert property (p_flash)
    else $error("start during flash");
  property p_mode;
    s_start |-> !(cell_program && $past(io_wdata[5:4]) == 2'h1)
      && !(cell_erase && $past(io_wdata[5:4]) == 2'h2);
  endproperty
  a_mode: assert property (p_mode)
    else $error("wrong phase for mode");
  property p_hold;
    busy && $past(busy) |-> $stable(cell_addr) && $stable(cell_wdata);
  endproperty
  a_hold: assert property (p_hold)
    else $error("address moved in flight");
  property p_rd;
    s_read |=> cell_rd ##1 !cell_rd;
  endproperty
  a_rd: assert property (p_rd)
    else $error("read pulse wrong");
  property p_stall_rd;
    s_read |=> cpu_stall [*4];
  endproperty
  a_stall_rd: assert property (p_stall_rd)
    else $error("read stall short");
  property p_stall_wr;
    s_start |-> cpu_stall [*2];
  endproperty
  a_stall_wr: assert property (p_stall_wr)
    else $error("write stall short");
endmodule // nvc_checker

// *** testbench/nvc_cell_model.sv ***
// behavioural cell array and oscillator for the access controller
`timescale 1ns/100ps
module nvc_cell_model (
  input wire core_clk, // clock
  input wire [8:0] cell_addr, // byte address
  input wire [7:0] cell_wdata, // byte to program
  input wire cell_erase, // erase phase
  input wire cell_program, // write phase
  output wire [7:0] cell_rdata, // byte read
  output reg osc_tick // oscillator pulse
);
  reg [7:0] mem [0:511];
  reg busy_q = 1'b0;
  reg er_seen = 1'b0;
  reg pg_seen = 1'b0;
  integer i;
  // erased cells read ones; a bare write can only clear bits
  initial begin
    for (i = 0; i < 512; i = i + 1) mem[i] = 8'hFF;
    osc_tick = 1'b1;
  end
  assign cell_rdata = mem[cell_addr];
  // the cell settles only when the whole operation ends
  always @(posedge core_clk) begin
    busy_q <= cell_erase | cell_program;
    er_seen <= (cell_erase | cell_program) & (er_seen | cell_erase);
    pg_seen <= (cell_erase | cell_program) & (pg_seen | cell_program);
    if (busy_q && !(cell_erase | cell_program))
      mem[cell_addr] <= (er_seen ? 8'hFF : mem[cell_addr])
        & (pg_seen ? cell_wdata : 8'hFF);
  end
endmodule // nvc_cell_model

// *** testbench/nvc_access_ctrl_test.sv ***
// self-checking bench for the nonvolatile access controller
`timescale 1ns/100ps
module nvc_access_ctrl_test;
  reg core_clk = 1'b0;
  reg rst = 1'b1;
  reg [5:0] io_addr = 6'h00;
  reg io_wr = 1'b0;
  reg io_rd = 1'b0;
  reg [7:0] io_wdata = 8'h00;
  reg global_irq_en = 1'b0;
  reg flash_selfprog_busy = 1'b0;
  wire [7:0] io_rdata, cell_wdata, cell_rdata;
  wire [8:0] cell_addr;
  wire osc_tick, ready_irq, cpu_stall, cell_erase, cell_program, cell_rd;
  reg [7:0] v;
  integer failures = 0;
  integer compares = 0;
  always #12.5 core_clk = ~core_clk;
  nvc_access_ctrl nvc_access_ctrl_inst (.core_clk(core_clk), .rst(rst),
    .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .global_irq_en(global_irq_en),
    .flash_selfprog_busy(flash_selfprog_busy), .osc_tick(osc_tick),
    .ready_irq(ready_irq), .cpu_stall(cpu_stall), .cell_addr(cell_addr),
    .cell_wdata(cell_wdata), .cell_erase(cell_erase),
    .cell_program(cell_program), .cell_rd(cell_rd), .cell_rdata(cell_rdata));
  nvc_cell_model nvc_cell_model_inst (.core_clk(core_clk),
    .cell_addr(cell_addr), .cell_wdata(cell_wdata), .cell_erase(cell_erase),
    .cell_program(cell_program), .cell_rdata(cell_rdata), .osc_tick(osc_tick));
  task complete_run; begin
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  end endtask
  task chk(input [7:0] got, input [7:0] exp); begin
    compares = compares + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  end endtask
  // one register write, strobe held through the taking edge
  task wr(input [5:0] a, input [7:0] d); begin
    @(posedge core_clk);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge core_clk);
    io_wr <= 1'b0;
  end endtask
  task rd(input [5:0] a); begin
    @(posedge core_clk);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge core_clk);
    io_rd <= 1'b0;
    @(posedge core_clk);
    v = io_rdata;
  end endtask
  // c holds mode and irq enable; unlock then strobe two cycles apart
  task prog(input [8:0] a, input [7:0] d, input [7:0] c); begin
    wr(6'h22, {7'h00, a[8]});
    wr(6'h21, a[7:0]);
    wr(6'h20, d);
    wr(6'h1F, c | 8'h04);
    wr(6'h1F, c | 8'h02);
  end endtask
  task wait_idle; integer n; begin
    v = 8'h02;
    n = 0;
    while (v[1] && n < 20000) begin
      rd(6'h1F);
      n = n + 1;
    end
    chk(v & 8'h02, 8'h00);
  end endtask
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    rd(6'h1F);
    chk(v, 8'h00);
    wr(6'h22, 8'hFF);
    rd(6'h22);
    chk(v, 8'h01);
    wr(6'h1F, 8'hC8);
    rd(6'h1F);
    chk(v, 8'h08);
    rd(6'h3E);
    chk(v, 8'h00);
    $display("register map test done");
    // refused starts: bare strobe, lapsed unlock, mode 11, flash busy
    wr(6'h1F, 8'h02);
    rd(6'h1F);
    chk(v, 8'h00);
    wr(6'h1F, 8'h04);
    repeat (6) @(posedge core_clk);
    wr(6'h1F, 8'h02);
    rd(6'h1F);
    chk(v, 8'h00);
    wr(6'h1F, 8'h34);
    wr(6'h1F, 8'h32);
    rd(6'h1F);
    chk(v, 8'h34);
    flash_selfprog_busy <= 1'b1;
    prog(9'h003, 8'h81, 8'h00);
    rd(6'h1F);
    chk(v, 8'h04);
    flash_selfprog_busy <= 1'b0;
    $display("refused start test done");
    // write only, with refused changes and a reset in flight
    prog(9'h1A5, 8'h3C, 8'h28);
    global_irq_en <= 1'b1;
    wr(6'h1F, 8'h18);
    wr(6'h21, 8'h00);
    chk({7'h00, ready_irq}, 8'h00);
    rd(6'h21);
    chk(v, 8'hA5);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rd(6'h1F);
    chk(v & 8'h32, 8'h22);
    wait_idle;
    wr(6'h1F, 8'h08);
    @(posedge core_clk);
    chk({7'h00, ready_irq}, 8'h01);
    flash_selfprog_busy <= 1'b1;
    @(posedge core_clk);
    chk({7'h00, ready_irq}, 8'h00);
    flash_selfprog_busy <= 1'b0;
    global_irq_en <= 1'b0;
    @(posedge core_clk);
    chk({7'h00, ready_irq}, 8'h00);
    wr(6'h1F, 8'h01);
    rd(6'h20);
    chk(v, 8'h3C);
    $display("write only test done");
    // erase only, then atomic rewrite, each read back from the array
    prog(9'h1A5, 8'h55, 8'h10);
    wait_idle;
    wr(6'h1F, 8'h01);
    rd(6'h20);
    chk(v, 8'hFF);
    prog(9'h1A5, 8'h81, 8'h00);
    wait_idle;
    wr(6'h20, 8'h00);
    wr(6'h1F, 8'h01);
    rd(6'h20);
    chk(v, 8'h81);
    $display("erase and atomic test done");
    complete_run;
  end
  // watchdog sized above the three programming runs plus polling
  initial begin
    repeat (90000) @(posedge core_clk);
    failures = failures + 1;
    $display("[ERR] %0t watchdog expired", $time);
    complete_run;
  end
endmodule // nvc_access_ctrl_test
bind nvc_access_ctrl nvc_checker #(.AW(AW)) nvc_checker_inst (
  .core_clk(core_clk), .rst(rst), .io_addr(io_addr), .io_wr(io_wr),
  .io_wdata(io_wdata), .global_irq_en(global_irq_en),
  .flash_selfprog_busy(flash_selfprog_busy), .ready_irq(ready_irq),
  .cpu_stall(cpu_stall), .cell_addr(cell_addr), .cell_wdata(cell_wdata),
  .cell_erase(cell_erase), .cell_program(cell_program), .cell_rd(cell_rd));
